// File: core/feature_presence_inquiry_regs.sv
// Feature presence inquiry bank behind an APB slave; read-only apart from the refresh control register.
// Operation
// - Presence bit one means available, zero not
// - Recompute presence on format or mode change
// - High word: brightness, shutter, gain, trigger present
// - Low word: zoom to capture controls absent
// - Optional word: parallel, strobe present; serial absent
// - 0x480 returns advanced space quadlet offset
// - 0x484 returns parallel I/O space offset
// - 0x48C returns strobe output space offset
`timescale 1ns/1ps
`default_nettype none
module feature_presence_inquiry_regs #(
    parameter logic [31:0] ADV_SPACE_QUADLET = 32'h0000_1000,
    parameter logic [31:0] PARALLEL_SPACE_QUADLET = 32'h0000_2000,
    parameter logic [31:0] STROBE_SPACE_QUADLET = 32'h0000_3000,
    parameter logic [7:0] FORMAT_ENABLE = 8'hff
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [inquiry_pkg::ADDR_W-1:0] PADDR,
    input wire logic [inquiry_pkg::DATA_W-1:0] PWDATA,
    output logic [inquiry_pkg::DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [inquiry_pkg::SEL_W-1:0] VIDEO_FORMAT,
    input wire logic [inquiry_pkg::SEL_W-1:0] VIDEO_MODE,
    output logic REFRESH_BUSY
);
    import inquiry_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_LOAD = 2'b10
    } refresh_state_type;

    refresh_state_type state;
    video_select_type sel;
    video_select_type held_sel;
    presence_words_type fresh;
    presence_words_type shown;
    logic sel_changed;
    logic force_refresh;
    logic freeze;
    logic [COUNT_W-1:0] refresh_count;
    logic access;
    logic complete;
    logic mapped;
    logic [DATA_W-1:0] next_rdata;

    // Selection comes from camera logic on this clock, so no synchroniser
    assign sel = {VIDEO_FORMAT, VIDEO_MODE};

    // Word lookup used by the read path only
    function automatic logic [DATA_W-1:0] read_word(
        input logic [ADDR_W-1:0] addr,
        input presence_words_type words,
        input logic frz,
        input video_select_type hs,
        input logic [COUNT_W-1:0] cnt
    );
        logic [DATA_W-1:0] w;
        w = ZERO_WORD;
        case (addr)
            OFS_FEATURE_HIGH: w = words.high;
            OFS_FEATURE_LOW: w = words.low;
            OFS_OPTIONAL: w = words.optional;
            OFS_ADV_POINTER: w = ADV_SPACE_QUADLET;
            OFS_PARALLEL_POINTER: w = PARALLEL_SPACE_QUADLET;
            OFS_STROBE_POINTER: w = STROBE_SPACE_QUADLET;
            OFS_REFRESH_CTRL: w[BIT_FREEZE] = frz;
            OFS_REFRESH_STATUS: begin
                w[STAT_FORMAT_LSB +: SEL_W] = hs.format;
                w[STAT_MODE_LSB +: SEL_W] = hs.mode;
                w[STAT_COUNT_LSB +: COUNT_W] = cnt;
            end
            default: w = ZERO_WORD;
        endcase
        return w;
    endfunction

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        case (addr)
            OFS_FEATURE_HIGH, OFS_FEATURE_LOW, OFS_OPTIONAL,
            OFS_ADV_POINTER, OFS_PARALLEL_POINTER, OFS_STROBE_POINTER,
            OFS_REFRESH_CTRL, OFS_REFRESH_STATUS: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    presence_calc #(
        .FORMAT_ENABLE(FORMAT_ENABLE)
    ) u_calc (
        .sel(sel),
        .words(fresh)
    );

    select_watch u_watch (
        .clk(CLK),
        .rst(SYS_RST),
        .sel(sel),
        .changed(sel_changed)
    );

    // Bus decode; the answer comes one cycle into the access phase
    assign access = PSEL && PENABLE && !PREADY;
    assign complete = PSEL && PENABLE && PREADY;
    assign mapped = is_mapped(PADDR);
    assign next_rdata = read_word(PADDR, shown, freeze, held_sel, refresh_count);

    // Refresh sequencer; reads wait while words are being reloaded
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state <= ST_LOAD;
        end else begin
            case (state)
                ST_IDLE: begin
                    if ((sel_changed && !freeze) || force_refresh) begin
                        state <= ST_LOAD;
                    end
                end
                ST_LOAD: state <= ST_IDLE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Presence words shown to the host, taken from the lookup on reload
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            shown <= '0;
            held_sel <= '0;
        end else if (state == ST_LOAD) begin
            shown <= fresh;
            held_sel <= sel;
        end
    end

    // Reload counter, wraps; lets software see that a reload happened
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            refresh_count <= '0;
        end else if (state == ST_LOAD) begin
            refresh_count <= refresh_count + 1'b1;
        end
    end

    // Control writes land on the completing edge only
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            freeze <= 1'b0;
            force_refresh <= 1'b0;
        end else if (complete && PWRITE && PADDR == OFS_REFRESH_CTRL) begin
            freeze <= PWDATA[BIT_FREEZE];
            force_refresh <= PWDATA[BIT_FORCE_REFRESH];
        end else if (state == ST_IDLE) begin
            force_refresh <= 1'b0; // Self-clearing once the reload starts
        end
    end

    // APB answer; inquiry words accept writes but never change
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            PREADY <= 1'b0;
            PRDATA <= '0;
            PSLVERR <= 1'b0;
        end else if (access && state == ST_IDLE) begin
            PREADY <= 1'b1;
            PSLVERR <= !mapped;
            PRDATA <= PWRITE ? ZERO_WORD : next_rdata;
        end else begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

    // Busy flag mirrors the reload for the rest of the camera
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            REFRESH_BUSY <= 1'b1;
        end else begin
            REFRESH_BUSY <= (state == ST_IDLE) &&
                ((sel_changed && !freeze) || force_refresh);
        end
    end

    // Checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    presence_value_a: assert property (
        PREADY && !PWRITE && PADDR == OFS_FEATURE_HIGH &&
        FORMAT_ENABLE[held_sel.format] |->
        PRDATA[BIT_BRIGHTNESS] && PRDATA[BIT_TRIGGER])
        else $error("available feature read as absent");

    change_reload_a: assert property (
        state == ST_IDLE && sel_changed && !freeze && !force_refresh |=>
        state == ST_LOAD ##1 held_sel == $past(sel))
        else $error("selection change did not reload presence words");

    high_word_a: assert property (
        state == ST_IDLE && FORMAT_ENABLE[held_sel.format] |->
        shown.high[15:0] == 16'h1181 && shown.high[31:16] == 16'h0000)
        else $error("high feature word wrong");

    low_word_a: assert property (
        state == ST_IDLE |-> shown.low[3:0] == 4'h0 &&
        shown.low[15:4] == 12'h000 && shown.low[17:16] == 2'b00)
        else $error("low feature word reports a feature");

    optional_word_a: assert property (
        state == ST_IDLE && FORMAT_ENABLE[held_sel.format] |->
        shown.optional[BIT_PARALLEL_IO] && shown.optional[BIT_STROBE] &&
        !shown.optional[BIT_SERIAL_IO])
        else $error("optional function word wrong");

    adv_pointer_a: assert property (
        PSEL && PENABLE && !PREADY && !PWRITE && PADDR == OFS_ADV_POINTER &&
        state == ST_IDLE |=> PREADY && PRDATA == ADV_SPACE_QUADLET)
        else $error("advanced space offset wrong");

    parallel_pointer_a: assert property (
        PREADY && !PWRITE && $past(PADDR) == OFS_PARALLEL_POINTER |->
        PRDATA == PARALLEL_SPACE_QUADLET)
        else $error("parallel I/O space offset wrong");

    strobe_pointer_a: assert property (
        PREADY && !PWRITE && $past(PADDR) == OFS_STROBE_POINTER |->
        PRDATA == STROBE_SPACE_QUADLET && !PSLVERR)
        else $error("strobe space offset wrong");

    write_ignored_a: assert property (
        complete && PWRITE && PADDR != OFS_REFRESH_CTRL && state == ST_IDLE &&
        !sel_changed && !force_refresh |=> $stable(shown) && $stable(freeze))
        else $error("write to inquiry register changed state");

    ready_pulse_a: assert property (
        PREADY |=> !PREADY)
        else $error("ready held longer than one cycle");

    answer_bound_a: assert property (
        PSEL && PENABLE |-> ##[0:3] PREADY)
        else $error("no answer within bound");

    // Error answers only for holes in the map, and only with ready
    error_with_ready_a: assert property (
        PSLVERR |-> PREADY)
        else $error("error flag without ready");

    unmapped_error_a: assert property (
        access && state == ST_IDLE && !mapped |=>
        PREADY && PSLVERR && PRDATA == ZERO_WORD)
        else $error("unmapped address not refused");

    mapped_clean_a: assert property (
        access && state == ST_IDLE && mapped |=> PREADY && !PSLVERR)
        else $error("mapped address answered with error");

    // A write answer never leaks register contents
    write_answer_a: assert property (
        access && state == ST_IDLE && PWRITE |=> PRDATA == ZERO_WORD)
        else $error("write answer carried data");

    // Absent and reserved bits read zero whatever the format
    high_absent_a: assert property (
        PREADY && !PWRITE && PADDR == OFS_FEATURE_HIGH |->
        PRDATA[6:1] == 6'h00 && PRDATA[11:9] == 3'h0 &&
        PRDATA[15:13] == 3'h0 && PRDATA[31:16] == 16'h0000)
        else $error("absent feature read as present");

    low_read_a: assert property (
        PREADY && !PWRITE && PADDR == OFS_FEATURE_LOW |-> PRDATA == ZERO_WORD)
        else $error("low feature word read nonzero");

    optional_reserved_a: assert property (
        PREADY && !PWRITE && PADDR == OFS_OPTIONAL |->
        !PRDATA[0] && !PRDATA[BIT_SERIAL_IO] && PRDATA[31:4] == 28'h0)
        else $error("optional word reserved or serial bit set");

    optional_present_a: assert property (
        PREADY && !PWRITE && PADDR == OFS_OPTIONAL &&
        FORMAT_ENABLE[held_sel.format] |->
        PRDATA[BIT_PARALLEL_IO] && PRDATA[BIT_STROBE])
        else $error("available function read as absent");

    // A masked format offers nothing, so every presence bit is clear
    masked_format_a: assert property (
        state == ST_IDLE && !FORMAT_ENABLE[held_sel.format] |-> shown == '0)
        else $error("masked format still reports features");

    // One load cycle per reload, and no answer while it runs
    load_stall_a: assert property (
        state == ST_LOAD |=> state == ST_IDLE && !PREADY)
        else $error("load longer than one cycle or answered");

    load_capture_a: assert property (
        state == ST_LOAD |=> held_sel == $past(sel))
        else $error("selection not captured on reload");

    busy_load_a: assert property (
        REFRESH_BUSY == (state == ST_LOAD))
        else $error("busy flag out of step with reload");

    // Freeze blocks selection reloads; a forced one still starts
    freeze_hold_a: assert property (
        state == ST_IDLE && freeze && !force_refresh |=> state == ST_IDLE)
        else $error("reload while frozen");

    force_start_a: assert property (
        state == ST_IDLE && force_refresh && !complete |=>
        state == ST_LOAD && !force_refresh)
        else $error("forced reload did not start or clear");

    ctrl_freeze_a: assert property (
        complete && PWRITE && PADDR == OFS_REFRESH_CTRL |=>
        freeze == $past(PWDATA[BIT_FREEZE]))
        else $error("freeze bit write did not land");

    force_reads_zero_a: assert property (
        PREADY && !PWRITE && PADDR == OFS_REFRESH_CTRL |-> !PRDATA[BIT_FORCE_REFRESH])
        else $error("force bit read back as set");

    // Reload counter steps once per load and otherwise holds
    count_step_a: assert property (
        state == ST_LOAD |=> refresh_count == $past(refresh_count) + 1'b1)
        else $error("reload count did not step");

    count_hold_a: assert property (
        state == ST_IDLE |=> $stable(refresh_count))
        else $error("reload count moved without reload");

    // Scenarios worth seeing exercised
    refresh_seen_c: cover property (
        state == ST_IDLE && sel_changed ##1 state == ST_LOAD);
    read_pointer_c: cover property (
        PREADY && !PWRITE && PADDR == OFS_ADV_POINTER);
    bad_address_c: cover property (PREADY && PSLVERR);
    frozen_change_c: cover property (freeze && sel_changed && state == ST_IDLE);
    forced_reload_c: cover property (
        force_refresh && state == ST_IDLE ##1 state == ST_LOAD);
endmodule
`default_nettype wire

// File: core/inquiry_pkg.sv
// Constants and types shared by the feature presence inquiry bank.
package inquiry_pkg;

    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int SEL_W = 3;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_FEATURE_HIGH = 12'h404;
    localparam logic [ADDR_W-1:0] OFS_FEATURE_LOW = 12'h408;
    localparam logic [ADDR_W-1:0] OFS_OPTIONAL = 12'h40c;
    localparam logic [ADDR_W-1:0] OFS_ADV_POINTER = 12'h480;
    localparam logic [ADDR_W-1:0] OFS_PARALLEL_POINTER = 12'h484;
    localparam logic [ADDR_W-1:0] OFS_STROBE_POINTER = 12'h48c;
    localparam logic [ADDR_W-1:0] OFS_REFRESH_CTRL = 12'h4a0;
    localparam logic [ADDR_W-1:0] OFS_REFRESH_STATUS = 12'h4a4;

    // High feature word bit positions
    localparam int BIT_BRIGHTNESS = 0;
    localparam int BIT_SHUTTER = 7;
    localparam int BIT_GAIN = 8;
    localparam int BIT_TRIGGER = 12;
    // Optional function word bit positions
    localparam int BIT_PARALLEL_IO = 1;
    localparam int BIT_SERIAL_IO = 2;
    localparam int BIT_STROBE = 3;

    // Refresh control and status fields
    localparam int BIT_FORCE_REFRESH = 0;
    localparam int BIT_FREEZE = 1;
    localparam int STAT_FORMAT_LSB = 0;
    localparam int STAT_MODE_LSB = 4;
    localparam int STAT_COUNT_LSB = 8;
    localparam int COUNT_W = 8;

    // Documented presence values
    localparam logic [DATA_W-1:0] HIGH_VALUE = 32'h0000_1181;
    localparam logic [DATA_W-1:0] LOW_VALUE = 32'h0000_0000;
    localparam logic [DATA_W-1:0] OPTIONAL_VALUE = 32'h0000_000a;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

    typedef struct packed {
        logic [DATA_W-1:0] high;
        logic [DATA_W-1:0] low;
        logic [DATA_W-1:0] optional;
    } presence_words_type;

    typedef struct packed {
        logic [SEL_W-1:0] format;
        logic [SEL_W-1:0] mode;
    } video_select_type;

endpackage

// File: core/presence_calc.sv
// Presence words worked out from the selected video format and mode.
`timescale 1ns/1ps
`default_nettype none
module presence_calc #(
    parameter logic [7:0] FORMAT_ENABLE = 8'hff
) (
    input wire inquiry_pkg::video_select_type sel,
    output inquiry_pkg::presence_words_type words
);
    import inquiry_pkg::*;

    // A format not built into the camera offers no features at all
    always_comb begin
        if (FORMAT_ENABLE[sel.format]) begin
            words.high = HIGH_VALUE;
            words.low = LOW_VALUE;
            words.optional = OPTIONAL_VALUE;
        end else begin
            words.high = ZERO_WORD;
            words.low = ZERO_WORD;
            words.optional = ZERO_WORD;
        end
    end
endmodule
`default_nettype wire

// File: core/select_watch.sv
// Flags a change of the video selection against its last seen value.
`timescale 1ns/1ps
`default_nettype none
module select_watch (
    input wire logic clk,
    input wire logic rst,
    input wire inquiry_pkg::video_select_type sel,
    output logic changed
);
    import inquiry_pkg::*;

    video_select_type seen;

    // Last selection; reset value flags one change after reset, which falls in the reset load
    always_ff @(posedge clk) begin
        if (rst) begin
            seen <= '1;
        end else begin
            seen <= sel;
        end
    end

    assign changed = (seen != sel);
endmodule
`default_nettype wire

// File: sim/feature_presence_inquiry_regs_tb.sv
// Self-checking bench for the feature presence inquiry bank.
`timescale 1ns/1ps
`default_nettype none
module feature_presence_inquiry_regs_tb;
    import inquiry_pkg::*;

    // Pointer values of our own choosing, distinct from the defaults
    localparam logic [31:0] ADV_Q = 32'h0000_0a40;
    localparam logic [31:0] PAR_Q = 32'h0000_0b80;
    localparam logic [31:0] STB_Q = 32'h0000_0c20;
    localparam int LIMIT = 5000;

    logic clk;
    logic sys_rst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic [SEL_W-1:0] vfmt;
    logic [SEL_W-1:0] vmode;
    logic refresh_busy;
    logic [ADDR_W-1:0] addrs [6];
    logic [DATA_W-1:0] vals [6];
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;

    // Format 1 masked off so a selection change really alters the words
    feature_presence_inquiry_regs #(
        .ADV_SPACE_QUADLET(ADV_Q),
        .PARALLEL_SPACE_QUADLET(PAR_Q),
        .STROBE_SPACE_QUADLET(STB_Q),
        .FORMAT_ENABLE(8'hfd)
    ) dut (
        .CLK(clk),
        .SYS_RST(sys_rst),
        .PSEL(psel),
        .PENABLE(penable),
        .PWRITE(pwrite),
        .PADDR(paddr),
        .PWDATA(pwdata),
        .PRDATA(prdata),
        .PREADY(pready),
        .PSLVERR(pslverr),
        .VIDEO_FORMAT(vfmt),
        .VIDEO_MODE(vmode),
        .REFRESH_BUSY(refresh_busy)
    );

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic conclude;
        if (err_total == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            err_total++;
            conclude;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic er);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] rd;
        logic er;
        xfer(1'b0, a, 32'h0000_0000, rd, er);
        chk(rd, exp, "read data");
        chk({31'h0, er}, {31'h0, experr}, "read error flag");
    endtask

    task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic experr);
        logic [31:0] rd;
        logic er;
        xfer(1'b1, a, d, rd, er);
        chk({31'h0, er}, {31'h0, experr}, "write error flag");
    endtask

    // Let a pending reload start and finish before the next access
    task automatic settle;
        repeat (2) @(posedge clk);
        while (refresh_busy !== 1'b0) @(posedge clk);
    endtask

    task automatic pick(input logic [2:0] f, input logic [2:0] m);
        vfmt <= f;
        vmode <= m;
        settle;
    endtask

    // Main sequence
    initial begin
        logic [31:0] rd;
        logic er;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        vfmt = 3'h0;
        vmode = 3'h0;
        addrs = '{OFS_FEATURE_HIGH, OFS_FEATURE_LOW, OFS_OPTIONAL,
                  OFS_ADV_POINTER, OFS_PARALLEL_POINTER, OFS_STROBE_POINTER};
        vals = '{32'h0000_1181, 32'h0000_0000, 32'h0000_000a, ADV_Q, PAR_Q, STB_Q};
        repeat (8) @(posedge clk);
        chk({31'h0, refresh_busy}, 32'h1, "busy during reset");
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        // Every word read back against its documented value
        for (int i = 0; i < 6; i++) begin
            rd_chk(addrs[i], vals[i], 1'b0);
        end
        // Inverted writes must leave every word untouched
        for (int i = 0; i < 6; i++) begin
            wr_chk(addrs[i], ~vals[i], 1'b0);
            rd_chk(addrs[i], vals[i], 1'b0);
        end
        rd_chk(12'h410, 32'h0000_0000, 1'b1);
        wr_chk(12'h7fc, 32'hffff_ffff, 1'b1);
        // Masked format: presence words drop to zero, then come back
        pick(3'h1, 3'h2);
        for (int i = 0; i < 3; i++) begin
            rd_chk(addrs[i], 32'h0000_0000, 1'b0);
        end
        xfer(1'b0, OFS_REFRESH_STATUS, 32'h0, rd, er);
        chk(rd & 32'h0000_ff77, 32'h0000_0221, "captured selection");
        pick(3'h0, 3'h5);
        rd_chk(OFS_FEATURE_HIGH, 32'h0000_1181, 1'b0);
        // Freeze holds the old words until a forced reload
        wr_chk(OFS_REFRESH_CTRL, 32'h0000_0002, 1'b0);
        pick(3'h1, 3'h5);
        rd_chk(OFS_FEATURE_HIGH, 32'h0000_1181, 1'b0);
        wr_chk(OFS_REFRESH_CTRL, 32'h0000_0003, 1'b0);
        settle;
        rd_chk(OFS_REFRESH_CTRL, 32'h0000_0002, 1'b0);
        rd_chk(OFS_FEATURE_HIGH, 32'h0000_0000, 1'b0);
        wr_chk(OFS_REFRESH_CTRL, 32'h0000_0000, 1'b0);
        pick(3'h0, 3'h5);
        rd_chk(OFS_OPTIONAL, 32'h0000_000a, 1'b0);
        conclude;
    end
endmodule
`default_nettype wire
